// file: src/hfa_pkg.sv
// Purpose: Shared constants, carriers and state layout of the HDLC frame assist
// Assumes: Byte-wide memory-mapped access from the embedded controller, one clock
// Notes: CRC is the reflected 16-bit frame check, bit 0 of each byte first
package hfa_pkg;

	localparam logic [15:0] HFA_ADDR_RX_BITS = 16'hdc00;
	localparam logic [15:0] HFA_ADDR_RX_PORT = 16'hdc01;
	localparam logic [15:0] HFA_ADDR_TX_BITS = 16'hdc02;
	localparam logic [15:0] HFA_ADDR_TX_PORT = 16'hdc03;
	localparam logic [15:0] HFA_ADDR_CTRL = 16'hdc04;
	localparam logic [15:0] HFA_ADDR_ZD_DATA = 16'hdc08;
	localparam logic [15:0] HFA_ADDR_ZD_STAT = 16'hdc09;
	localparam logic [15:0] HFA_ADDR_CRC_LO = 16'hdc0a;
	localparam logic [15:0] HFA_ADDR_CRC_HI = 16'hdc0b;

	localparam int HFA_RXB_DEPTH = 16;
	localparam int HFA_RXQ_DEPTH = 21;
	localparam int HFA_TXQ_DEPTH = 21;
	localparam int HFA_TXO_BYTES = 16;
	localparam logic [4:0] HFA_RXB_FULL = 5'h10;
	localparam logic [4:0] HFA_Q_FULL = 5'h15;
	localparam logic [7:0] HFA_TXO_FULL = 8'h80;
	localparam logic [4:0] HFA_THR_LOW = 5'h0b;
	localparam logic [4:0] HFA_THR_HIGH = 5'h10;

	localparam logic [7:0] HFA_FLAG = 8'h7e;
	localparam logic [3:0] HFA_BYTE_BITS = 4'h8;
	localparam logic [2:0] HFA_STUFF_RUN = 3'h5;

	localparam int HFA_CS_TX_READY = 0;
	localparam int HFA_CS_RX_DATA = 1;
	localparam int HFA_CS_THR_SEL = 2;
	localparam int HFA_CS_TX_LEVEL = 3;
	localparam int HFA_CS_TX_DATA = 4;
	localparam int HFA_CS_RX_EMPTY = 5;
	localparam int HFA_CS_HOLD = 6;
	localparam int HFA_ZD_READY = 0;
	localparam int HFA_ZD_END = 1;
	localparam int HFA_ZD_OK = 2;
	localparam int HFA_ZD_IN_EMPTY = 3;
	localparam int HFA_ZD_RST = 7;

	localparam logic [15:0] HFA_CRC_INIT = 16'hffff;
	localparam logic [15:0] HFA_CRC_POLY = 16'h8408;
	localparam logic [15:0] HFA_CRC_GOOD = 16'hf0b8;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} hfa_bus_req_t;

	typedef struct packed {
		logic [HFA_RXB_DEPTH-1:0][7:0] rxb;
		logic [4:0] rxb_cnt;
		logic rx_busy;
		logic [7:0] rx_left;
		logic [4:0] rx_idx;
		logic [HFA_RXQ_DEPTH-1:0][7:0] rxq;
		logic [4:0] rxq_cnt;
		logic [HFA_TXQ_DEPTH-1:0][7:0] txq;
		logic [4:0] txq_cnt;
		logic tx_busy;
		logic [7:0] tx_left;
		logic [7:0] tx_sh;
		logic [3:0] tx_sh_n;
		logic tx_sh_flag;
		logic [2:0] tx_ones;
		logic tx_stuff;
		logic [HFA_TXO_BYTES*8-1:0] txo;
		logic [7:0] txo_wr;
		logic [3:0] txo_rd;
		logic tx_ready;
		logic rx_data;
		logic thr_sel;
		logic hold;
		logic tx_done;
		logic [7:0] zi;
		logic zi_full;
		logic [3:0] zi_n;
		logic [7:0] zraw;
		logic [3:0] zraw_n;
		logic [7:0] zsh;
		logic [3:0] zsh_n;
		logic [2:0] zones;
		logic [7:0] zo;
		logic zo_full;
		logic zend;
		logic zok;
		logic [15:0] crc;
		logic [7:0] rdata;
	} hfa_state_t;

	function automatic logic [15:0] hfa_crc_step(input logic [15:0] crc, input logic b);
		hfa_crc_step = (crc >> 1) ^ ((crc[0] ^ b) ? HFA_CRC_POLY : 16'h0000);
	endfunction

	function automatic logic [3:0] hfa_take(input logic [7:0] left);
		hfa_take = (left > 8'(HFA_BYTE_BITS)) ? HFA_BYTE_BITS : left[3:0];
	endfunction

endpackage

// file: src/hfa_frame_assist.sv
// Purpose: HDLC assist: receive deframer, transmit framer, zero-deletion helper
// Assumes: Controller strobes bus_req.wr or bus_req.rd for one cycle per byte access
// Notes: Read data appears on bus_rdata one cycle after the read strobe
`timescale 1ns/100ps

module hfa_frame_assist
	import hfa_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire hfa_bus_req_t bus_req,
	output logic [7:0] bus_rdata
);

	localparam hfa_state_t HFA_STATE_RST = '{crc: HFA_CRC_INIT, default: '0};

	hfa_state_t s_reg;
	hfa_state_t s_next;

	always_comb begin
		logic wr_hit;
		logic rd_hit;
		logic [4:0] thr;
		logic [3:0] nb;
		logic [7:0] byte_v;
		logic b;
		logic [7:0] raw;
		s_next = s_reg;
		wr_hit = bus_req.wr;
		rd_hit = bus_req.rd;
		thr = s_reg.thr_sel ? HFA_THR_HIGH : HFA_THR_LOW;
		nb = '0;
		byte_v = '0;
		b = 1'b0;
		raw = '0;

		// Reads first, so a pop and a push in one cycle both land
		if (rd_hit) begin
			s_next.rdata = 8'h00;
			case (bus_req.addr)
				HFA_ADDR_RX_PORT: begin
					s_next.rdata = s_reg.rxq[0];
					if (s_reg.rxq_cnt != 5'h00) begin
						for (int i = 0; i < HFA_RXQ_DEPTH - 1; i++) begin
							s_next.rxq[i] = s_reg.rxq[i+1];
						end
						s_next.rxq_cnt = 5'(s_reg.rxq_cnt - 5'h01);
					end
				end
				HFA_ADDR_TX_PORT: begin
					s_next.rdata = s_reg.txo[{s_reg.txo_rd, 3'h0} +: 8];
					s_next.txo_rd = 4'(s_reg.txo_rd + 4'h1);
				end
				HFA_ADDR_CTRL: begin
					s_next.rdata[HFA_CS_TX_READY] = s_reg.tx_ready;
					s_next.rdata[HFA_CS_RX_DATA] = s_reg.rx_data;
					s_next.rdata[HFA_CS_THR_SEL] = s_reg.thr_sel;
					s_next.rdata[HFA_CS_TX_LEVEL] = (s_reg.txq_cnt < thr);
					s_next.rdata[HFA_CS_TX_DATA] = s_reg.tx_done;
					s_next.rdata[HFA_CS_RX_EMPTY] = (s_reg.rxq_cnt == 5'h00);
					s_next.rdata[HFA_CS_HOLD] = s_reg.hold;
				end
				HFA_ADDR_ZD_DATA: begin
					s_next.rdata = s_reg.zo;
					s_next.zo_full = 1'b0;
				end
				HFA_ADDR_ZD_STAT: begin
					s_next.rdata[HFA_ZD_READY] = s_reg.zo_full;
					s_next.rdata[HFA_ZD_END] = s_reg.zend;
					s_next.rdata[HFA_ZD_OK] = s_reg.zok;
					s_next.rdata[HFA_ZD_IN_EMPTY] = ~s_reg.zi_full;
				end
				HFA_ADDR_CRC_LO: s_next.rdata = s_reg.crc[7:0];
				HFA_ADDR_CRC_HI: s_next.rdata = s_reg.crc[15:8];
				default: s_next.rdata = 8'h00;
			endcase
		end

		// Receive deframer, one buffered byte per cycle; stalls on a full queue
		if (s_reg.rx_busy) begin
			if (s_reg.rx_left == 8'h00 || s_reg.rx_idx >= s_reg.rxb_cnt) begin
				s_next.rx_busy = 1'b0;
				s_next.rxb_cnt = 5'h00;
				s_next.rx_data = 1'b0;
			end else if (s_next.rxq_cnt < HFA_Q_FULL) begin
				nb = hfa_take(s_reg.rx_left);
				byte_v = s_reg.rxb[s_reg.rx_idx[3:0]] & (8'hff >> (HFA_BYTE_BITS - nb));
				if (byte_v != HFA_FLAG) begin
					s_next.rxq[s_next.rxq_cnt] = byte_v;
					s_next.rxq_cnt = 5'(s_next.rxq_cnt + 5'h01);
				end
				s_next.rx_left = 8'(s_reg.rx_left - 8'(nb));
				s_next.rx_idx = 5'(s_reg.rx_idx + 5'h01);
			end
		end

		// Transmit framer, at most one output bit per cycle; a byte-load cycle emits none
		if (s_reg.tx_busy) begin
			if (s_reg.txo_wr >= HFA_TXO_FULL) begin
				s_next.tx_busy = 1'b0;
			end else if (s_reg.tx_stuff) begin
				s_next.txo[s_reg.txo_wr[6:0]] = 1'b0;
				s_next.txo_wr = 8'(s_reg.txo_wr + 8'h01);
				s_next.tx_stuff = 1'b0;
				s_next.tx_ones = 3'h0;
			end else if (s_reg.tx_sh_n == 4'h0) begin
				if (s_reg.tx_left == 8'h00) begin
					s_next.tx_busy = 1'b0;
					s_next.tx_done = 1'b1;
				end else if (s_reg.txq_cnt != 5'h00) begin
					s_next.tx_sh = s_reg.txq[0];
					s_next.tx_sh_n = hfa_take(s_reg.tx_left);
					s_next.tx_sh_flag = 1'b0;
					for (int i = 0; i < HFA_TXQ_DEPTH - 1; i++) begin
						s_next.txq[i] = s_reg.txq[i+1];
					end
					s_next.txq_cnt = 5'(s_reg.txq_cnt - 5'h01);
				end else begin
					s_next.tx_sh = HFA_FLAG;
					s_next.tx_sh_n = HFA_BYTE_BITS;
					s_next.tx_sh_flag = 1'b1;
					s_next.tx_ready = 1'b0;
				end
			end else begin
				b = s_reg.tx_sh[0];
				s_next.txo[s_reg.txo_wr[6:0]] = b;
				s_next.txo_wr = 8'(s_reg.txo_wr + 8'h01);
				s_next.tx_sh = s_reg.tx_sh >> 1;
				s_next.tx_sh_n = 4'(s_reg.tx_sh_n - 4'h1);
				if (s_reg.tx_sh_flag) begin
					// Flags are never stuffed and break any run of ones
					s_next.tx_ones = 3'h0;
				end else begin
					s_next.tx_left = 8'(s_reg.tx_left - 8'h01);
					s_next.tx_ones = b ? 3'(s_reg.tx_ones + 3'h1) : 3'h0;
					s_next.tx_stuff = b && (3'(s_reg.tx_ones + 3'h1) == HFA_STUFF_RUN);
				end
			end
		end
		if (s_next.txq_cnt >= thr) begin
			s_next.tx_ready = 1'b1;
		end

		// Zero-deletion helper; bits leave an 8-bit window so flag bits never reach output
		if (s_reg.zsh_n == HFA_BYTE_BITS && !s_next.zo_full) begin
			s_next.zo = s_reg.zsh;
			s_next.zo_full = 1'b1;
			s_next.zsh_n = 4'h0;
		end else if (s_reg.zi_full && s_reg.zsh_n != HFA_BYTE_BITS) begin
			b = s_reg.zi[s_reg.zi_n[2:0]];
			raw = {b, s_reg.zraw[7:1]};
			s_next.zraw = raw;
			s_next.zi_n = 4'(s_reg.zi_n + 4'h1);
			if (s_next.zi_n == HFA_BYTE_BITS) begin
				s_next.zi_full = 1'b0;
			end
			if (raw == HFA_FLAG) begin
				s_next.zend = 1'b1;
				s_next.zok = (s_reg.crc == HFA_CRC_GOOD);
				s_next.crc = HFA_CRC_INIT;
				s_next.zraw_n = 4'h0;
				s_next.zsh_n = 4'h0;
				s_next.zones = 3'h0;
			end else if (s_reg.zraw_n != HFA_BYTE_BITS) begin
				s_next.zraw_n = 4'(s_reg.zraw_n + 4'h1);
			end else if (s_reg.zones == HFA_STUFF_RUN && !s_reg.zraw[0]) begin
				s_next.zones = 3'h0;
			end else begin
				s_next.zsh = {s_reg.zraw[0], s_reg.zsh[7:1]};
				s_next.zsh_n = 4'(s_reg.zsh_n + 4'h1);
				s_next.crc = hfa_crc_step(s_reg.crc, s_reg.zraw[0]);
				if (!s_reg.zraw[0]) begin
					s_next.zones = 3'h0;
				end else if (s_reg.zones != 3'h7) begin
					s_next.zones = 3'(s_reg.zones + 3'h1);
				end
			end
		end

		// Writes last: firmware actions win over engine updates of the same cycle
		if (wr_hit) begin
			case (bus_req.addr)
				HFA_ADDR_RX_BITS: begin
					s_next.rx_left = bus_req.wdata;
					s_next.rx_idx = 5'h00;
					s_next.rx_busy = 1'b1;
				end
				HFA_ADDR_RX_PORT: begin
					if (s_next.rxb_cnt < HFA_RXB_FULL && !s_reg.rx_busy) begin
						s_next.rxb[s_next.rxb_cnt[3:0]] = bus_req.wdata;
						s_next.rxb_cnt = 5'(s_next.rxb_cnt + 5'h01);
					end
				end
				HFA_ADDR_TX_BITS: begin
					s_next.tx_left = bus_req.wdata;
					s_next.tx_done = 1'b0;
					s_next.tx_busy = 1'b1;
					s_next.txo_wr = 8'h00;
					s_next.txo_rd = 4'h0;
					s_next.tx_sh_n = 4'h0;
					s_next.tx_stuff = 1'b0;
					s_next.tx_ones = 3'h0;
				end
				HFA_ADDR_TX_PORT: begin
					if (s_next.txq_cnt < HFA_Q_FULL) begin
						s_next.txq[s_next.txq_cnt] = bus_req.wdata;
						s_next.txq_cnt = 5'(s_next.txq_cnt + 5'h01);
					end
				end
				HFA_ADDR_CTRL: begin
					s_next.rx_data = bus_req.wdata[HFA_CS_RX_DATA];
					s_next.thr_sel = bus_req.wdata[HFA_CS_THR_SEL];
					s_next.hold = bus_req.wdata[HFA_CS_HOLD];
				end
				HFA_ADDR_ZD_DATA: begin
					s_next.zi = bus_req.wdata;
					s_next.zi_full = 1'b1;
					s_next.zi_n = 4'h0;
				end
				HFA_ADDR_ZD_STAT: begin
					if (bus_req.wdata[HFA_ZD_RST]) begin
						s_next.zi_full = 1'b0;
						s_next.zi_n = 4'h0;
						s_next.zraw = 8'h00;
						s_next.zraw_n = 4'h0;
						s_next.zsh_n = 4'h0;
						s_next.zones = 3'h0;
						s_next.zo_full = 1'b0;
						s_next.zend = 1'b0;
						s_next.zok = 1'b0;
						s_next.crc = HFA_CRC_INIT;
					end
				end
				default: begin
				end
			endcase
		end

		// Held reset clears both HDLC paths and rx_data but keeps thr_sel and hold
		if (s_next.hold) begin
			s_next.rxb_cnt = 5'h00;
			s_next.rx_busy = 1'b0;
			s_next.rxq_cnt = 5'h00;
			s_next.txq_cnt = 5'h00;
			s_next.tx_busy = 1'b0;
			s_next.tx_sh_n = 4'h0;
			s_next.tx_stuff = 1'b0;
			s_next.tx_ones = 3'h0;
			s_next.txo_wr = 8'h00;
			s_next.txo_rd = 4'h0;
			s_next.tx_ready = 1'b0;
			s_next.tx_done = 1'b0;
			s_next.rx_data = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s_reg <= HFA_STATE_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign bus_rdata = s_reg.rdata;

endmodule

// file: bench/hfa_sva.sv
// Purpose: Port-level properties of the HDLC frame assist
// Assumes: One clock; bus strobes last one cycle each
// Notes: Read data is judged one edge after the read strobe
`timescale 1ns/100ps
module hfa_sva
	import hfa_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire hfa_bus_req_t bus_req,
	input wire logic [7:0] bus_rdata
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	logic rd;
	logic wr;
	logic [15:0] a;
	logic [7:0] wd;
	assign rd = bus_req.rd;
	assign wr = bus_req.wr;
	assign a = bus_req.addr;
	assign wd = bus_req.wdata;
	property p_hold;
		wr && a == HFA_ADDR_CTRL && wd[6] && !wd[1] ##2 rd && a == HFA_ADDR_CTRL
		|=> bus_rdata == {2'b01, 2'b10, 1'b1, $past(wd[2], 3), 2'b00};
	endproperty
	a_hold: assert property (p_hold) else $error("hold status wrong");
	property p_rdy;
		rd && a == HFA_ADDR_ZD_DATA ##2 rd && a == HFA_ADDR_ZD_STAT |=> !bus_rdata[0];
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready not cleared by read");
	property p_inb;
		wr && a == HFA_ADDR_ZD_DATA ##2 rd && a == HFA_ADDR_ZD_STAT |=> !bus_rdata[3];
	endproperty
	a_inb: assert property (p_inb) else $error("input still empty");
	property p_zrst;
		wr && a == HFA_ADDR_ZD_STAT && wd[7] ##2 rd && a == HFA_ADDR_ZD_STAT
		|=> bus_rdata[3:0] == 4'h8;
	endproperty
	a_zrst: assert property (p_zrst) else $error("helper flags survive reset");
	property p_crc;
		wr && a == HFA_ADDR_ZD_STAT && wd[7] ##2 rd && a == HFA_ADDR_CRC_LO
		|=> bus_rdata == 8'hff;
	endproperty
	a_crc: assert property (p_crc) else $error("check low not preset");
	property p_unm;
		rd && (a == 16'hdc05 || a == 16'hdc0f) |=> bus_rdata == 8'h00;
	endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	property p_keep;
		!rd |=> $stable(bus_rdata);
	endproperty
	a_keep: assert property (p_keep) else $error("read data moved");
	property p_txd;
		wr && a == HFA_ADDR_TX_BITS && wd != 8'h00 ##2 rd && a == HFA_ADDR_CTRL
		|=> !bus_rdata[4];
	endproperty
	a_txd: assert property (p_txd) else $error("tx data not cleared");
	c_rx: cover property (wr && a == HFA_ADDR_RX_BITS);
	c_tx: cover property (wr && a == HFA_ADDR_TX_BITS);
	c_zd: cover property (rd && a == HFA_ADDR_ZD_DATA);
endmodule

// file: bench/hfa_fw_model.sv
// Purpose: Controller-side byte master for the HDLC frame assist
// Assumes: Callers enter at a falling edge
// Notes: Idle address and data show inverted values; one idle cycle follows each access
`timescale 1ns/100ps
module hfa_fw_model
	import hfa_pkg::*;
(
	input wire logic core_clk,
	input wire logic [7:0] bus_rdata,
	output hfa_bus_req_t bus_req
);
	logic [7:0] rv;
	initial begin
		bus_req = '0;
	end
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		bus_req.addr = a;
		bus_req.wdata = d;
		bus_req.wr = 1'b1;
		@(negedge core_clk);
		bus_req.wr = 1'b0;
		bus_req.addr = ~a;
		bus_req.wdata = ~d;
		// Idle edge so a following call never re-drives the strobe in one step
		@(negedge core_clk);
	endtask
	task automatic rd(input logic [15:0] a);
		bus_req.addr = a;
		bus_req.rd = 1'b1;
		@(negedge core_clk);
		bus_req.rd = 1'b0;
		bus_req.addr = ~a;
		rv = bus_rdata;
		@(negedge core_clk);
	endtask
endmodule

// file: bench/tb_hfa_frame_assist.sv
// Purpose: Self-checking bench of the HDLC frame assist
// Assumes: Firmware model drives the bus at falling edges
// Notes: Random bytes from a fixed seed, with flag and all-ones corners
`timescale 1ns/100ps
module tb_hfa_frame_assist
	import hfa_pkg::*;
;
	logic core_clk;
	logic nrst;
	hfa_bus_req_t bus_req;
	logic [7:0] bus_rdata;
	int mismatches = 0;
	int checks_done = 0;
	hfa_frame_assist u_hfa_frame_assist (.core_clk(core_clk), .nrst(nrst),
		.bus_req(bus_req), .bus_rdata(bus_rdata));
	hfa_fw_model u_hfa_fw_model (.core_clk(core_clk), .bus_rdata(bus_rdata),
		.bus_req(bus_req));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		u_hfa_fw_model.wr(a, d);
	endtask
	task automatic rchk(input logic [15:0] a, input logic [7:0] e, input string n);
		u_hfa_fw_model.rd(a);
		chk(n, e, u_hfa_fw_model.rv);
	endtask
	task automatic poll(input logic [15:0] a, input int bi, input logic v, input int lim);
		for (int i = 0; i < lim; i++) begin
			u_hfa_fw_model.rd(a);
			if (u_hfa_fw_model.rv[bi] === v) return;
		end
		mismatches++;
		$display("CHECK FAILED wait %h expected %b seen timeout", a, v);
		end_of_test();
	endtask
	// Zero after every fifth one, bit 0 of each byte first
	function automatic int stuff(input logic [7:0] q[$], output logic [127:0] o);
		int n;
		int ones;
		n = 0;
		ones = 0;
		o = '0;
		foreach (q[i]) for (int j = 0; j < 8; j++) begin
			o[n] = q[i][j];
			n++;
			ones = q[i][j] ? ones + 1 : 0;
			if (ones == 5) begin
				n++;
				ones = 0;
			end
		end
		return n;
	endfunction
	initial begin
		int t;
		int n;
		int nb;
		int k;
		logic [7:0] b;
		logic [7:0] m;
		logic [7:0] q[$];
		logic [7:0] e[$];
		logic [127:0] o;
		nrst = 1'b0;
		void'($urandom(32'h3091));
		repeat (2) @(negedge core_clk);
		nrst = 1'b1;
		rchk(HFA_ADDR_CTRL, 8'h28, "ctrl_rst");
		rchk(HFA_ADDR_ZD_STAT, 8'h08, "zd_rst");
		rchk(HFA_ADDR_CRC_HI, 8'hff, "crc_hi");
		rchk(16'hdc05, 8'h00, "unmapped");
		for (t = 0; t < 4; t++) begin
			n = (t == 0) ? 16 : $urandom_range(15, 1);
			q.delete();
			e.delete();
			for (int i = 0; i < n; i++) begin
				b = (i == 1) ? HFA_FLAG : 8'($urandom);
				q.push_back(b);
				wr(HFA_ADDR_RX_PORT, b);
			end
			nb = 8 * n - $urandom_range(7, 0);
			foreach (q[j]) begin
				k = nb - 8 * j;
				m = (k >= 8) ? q[j] : q[j] & 8'((1 << k) - 1);
				if (m != HFA_FLAG) e.push_back(m);
			end
			wr(HFA_ADDR_CTRL, 8'h02);
			wr(HFA_ADDR_RX_BITS, 8'(nb));
			poll(HFA_ADDR_CTRL, 1, 1'b0, 40);
			rchk(HFA_ADDR_CTRL, (e.size() > 0) ? 8'h08 : 8'h28, "rx_stat");
			foreach (e[j]) rchk(HFA_ADDR_RX_PORT, e[j], "rx_byte");
			rchk(HFA_ADDR_CTRL, 8'h28, "rx_drained");
		end
		wr(HFA_ADDR_CTRL, 8'h40);
		rchk(HFA_ADDR_CTRL, 8'h68, "hold");
		wr(HFA_ADDR_CTRL, 8'h00);
		q.delete();
		for (int i = 0; i < 11; i++) begin
			b = (i < 2) ? 8'hff : 8'($urandom);
			q.push_back(b);
			wr(HFA_ADDR_TX_PORT, b);
			if (i == 9) rchk(HFA_ADDR_CTRL, 8'h28, "below_thr");
		end
		rchk(HFA_ADDR_CTRL, 8'h21, "at_thr");
		wr(HFA_ADDR_CTRL, 8'h04);
		rchk(HFA_ADDR_CTRL, 8'h2d, "thr_high");
		wr(HFA_ADDR_TX_BITS, 8'd88);
		poll(HFA_ADDR_CTRL, 4, 1'b1, 300);
		nb = stuff(q, o);
		for (int i = 0; 8 * i < nb; i++) begin
			m = (nb - 8 * i >= 8) ? 8'hff : 8'((1 << (nb - 8 * i)) - 1);
			u_hfa_fw_model.rd(HFA_ADDR_TX_PORT);
			chk("tx_byte", o[8 * i +: 8] & m, u_hfa_fw_model.rv & m);
		end
		wr(HFA_ADDR_TX_BITS, 8'h08);
		// Empty queue: framer idles on uncounted flags and sets tx_done only once data arrives
		poll(HFA_ADDR_CTRL, 0, 1'b0, 20);
		wr(HFA_ADDR_TX_PORT, 8'h00);
		poll(HFA_ADDR_CTRL, 4, 1'b1, 400);
		rchk(HFA_ADDR_TX_PORT, HFA_FLAG, "idle_flag");
		rchk(HFA_ADDR_TX_PORT, 8'h00, "after_flag");
		u_hfa_fw_model.rd(HFA_ADDR_CTRL);
		chk("tx_ready", 8'h00, {7'h00, u_hfa_fw_model.rv[0]});
		wr(HFA_ADDR_ZD_STAT, 8'h80);
		rchk(HFA_ADDR_CRC_LO, 8'hff, "zd_crc");
		wr(HFA_ADDR_ZD_DATA, HFA_FLAG);
		rchk(HFA_ADDR_ZD_STAT, 8'h00, "zd_busy");
		poll(HFA_ADDR_ZD_STAT, 3, 1'b1, 20);
		u_hfa_fw_model.rd(HFA_ADDR_ZD_STAT);
		chk("zd_end", 8'h0a, u_hfa_fw_model.rv & 8'h0a);
		for (int i = 0; i < 2; i++) begin
			wr(HFA_ADDR_ZD_DATA, 8'h00);
			poll(HFA_ADDR_ZD_STAT, 3, 1'b1, 20);
		end
		poll(HFA_ADDR_ZD_STAT, 0, 1'b1, 40);
		rchk(HFA_ADDR_ZD_DATA, 8'h00, "zd_out");
		u_hfa_fw_model.rd(HFA_ADDR_ZD_STAT);
		chk("zd_ready", 8'h00, {7'h00, u_hfa_fw_model.rv[0]});
		wr(HFA_ADDR_ZD_STAT, 8'h80);
		rchk(HFA_ADDR_ZD_STAT, 8'h08, "zd_clear");
		end_of_test();
	end
endmodule
bind hfa_frame_assist hfa_sva u_hfa_sva (.core_clk(core_clk), .nrst(nrst),
	.bus_req(bus_req), .bus_rdata(bus_rdata));
